/* design/gpbcd_pkg.sv */
// constants and carrier types for the general-purpose port block
// Function
// - reset clears every direction bit, so all pins start as inputs.
// - direction 1 enables the pin's output driver; 0 leaves it an input.
// - first port data read returns latch for output bits, pin for input bits.
// - seven-bit port data read returns pin for input bits, latch for output bits.
// - third port data read returns latch or pin by direction, even for peripheral pins.
// - data latches accept writes whenever reset is low, regardless of direction.
// - reset leaves the output data latches unchanged.
// - writing an input pin's data bit changes only the latch, not the read value.
// - pullup enable 1 connects pullup on an input pin; 0 leaves it floating.
// - pullup forced off whenever the pin's output driver is on, by direction or by the owning peripheral.
// - second port has seven pins, each with data, direction and pullup bits.
// - third port has eight pins, four shared with SPI, four with timers, with pullups.
// - with SPI disabled, clock, MOSI and MISO pins return to port control.
// - slave-select pin is port I/O when SPI is disabled or master select is set.
// - with SPI enabled and master select clear, third port direction bit 0 has no effect on slave-select drive.
// - on SPI-owned pins direction does not steer the pin but still selects read source.
// - each timer channel's edge/level field picks timer or port use of its pin.
// - the converter's selected channel forces that first-port pin to analog input.
package gpbcd_pkg;

  localparam logic [3:0] GPBCD_OFS_B_DATA  = 4'h1;
  localparam logic [3:0] GPBCD_OFS_C_DATA  = 4'h2;
  localparam logic [3:0] GPBCD_OFS_D_DATA  = 4'h3;
  localparam logic [3:0] GPBCD_OFS_B_DIR   = 4'h5;
  localparam logic [3:0] GPBCD_OFS_C_DIR   = 4'h6;
  localparam logic [3:0] GPBCD_OFS_D_DIR   = 4'h7;
  localparam logic [3:0] GPBCD_OFS_C_PUE   = 4'h8;
  localparam logic [3:0] GPBCD_OFS_D_PUE   = 4'h9;
  localparam logic [3:0] GPBCD_OFS_ADC_SEL = 4'hA;

  localparam logic [7:0] GPBCD_DIR_RST   = 8'h00;
  localparam logic [7:0] GPBCD_PUE_RST   = 8'h00;
  localparam logic [4:0] GPBCD_ADC_RST   = 5'h1F;
  localparam int         GPBCD_ADC_CHANS = 8;

  // pin bit positions on the third port
  localparam int GPBCD_D_SS   = 0;
  localparam int GPBCD_D_MISO = 1;
  localparam int GPBCD_D_MOSI = 2;
  localparam int GPBCD_D_SCK  = 3;
  localparam int GPBCD_D_TMR  = 4;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } gpbcd_bus_s;

  // peripheral ownership: SPI enable and master select, per pin timer enable, plus drive value and direction
  typedef struct packed {
    logic       spi_enable_signal;
    logic       spi_master_select;
    logic [3:0] spi_out;
    logic [3:0] spi_oe;
    logic [3:0] tmr_active;
    logic [3:0] tmr_out;
    logic [3:0] tmr_oe;
  } gpbcd_periph_s;

  typedef struct packed {
    logic [7:0] port_b_data_latch;
    logic [6:0] port_c_data_latch;
    logic [7:0] port_d_data_latch;
    logic [7:0] port_b_direction;
    logic [6:0] port_c_direction;
    logic [7:0] port_d_direction;
    logic [6:0] port_c_pullup_enable;
    logic [7:0] port_d_pullup_enable;
    logic [4:0] converter_channel_select;
    logic [7:0] b_meta;
    logic [7:0] b_sync;
    logic [6:0] c_meta;
    logic [6:0] c_sync;
    logic [7:0] d_meta;
    logic [7:0] d_sync;
    logic [7:0] rdata;
    logic [7:0] b_out;
    logic [7:0] b_oe;
    logic [7:0] b_analog;
    logic [6:0] c_out;
    logic [6:0] c_oe;
    logic [6:0] c_pu;
    logic [7:0] d_out;
    logic [7:0] d_oe;
    logic [7:0] d_pu;
  } gpbcd_state_s;

endpackage : gpbcd_pkg

/* design/gpbcd_ports.sv */
// general-purpose ports b, c and d with register access and peripheral sharing
`timescale 1ns/100ps
`default_nettype none
module gpbcd_ports (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire gpbcd_pkg::gpbcd_bus_s   bus,
  output logic [7:0]                   rdata,
  input  wire gpbcd_pkg::gpbcd_periph_s periph,
  input  wire logic [7:0]              b_pin_in,
  output logic [7:0]                   b_pin_out,
  output logic [7:0]                   b_pin_oe,
  output logic [7:0]                   b_analog_sel,
  input  wire logic [6:0]              c_pin_in,
  output logic [6:0]                   c_pin_out,
  output logic [6:0]                   c_pin_oe,
  output logic [6:0]                   c_pullup_on,
  input  wire logic [7:0]              d_pin_in,
  output logic [7:0]                   d_pin_out,
  output logic [7:0]                   d_pin_oe,
  output logic [7:0]                   d_pullup_on,
  output logic [7:0]                   d_spi_in
);

  gpbcd_pkg::gpbcd_state_s s_q;
  gpbcd_pkg::gpbcd_state_s s_d;

  // one select per register, shared by the write and read paths
  logic             sel_b_data;
  logic             sel_c_data;
  logic             sel_d_data;
  logic             sel_b_dir;
  logic             sel_c_dir;
  logic             sel_d_dir;
  logic             sel_c_pue;
  logic             sel_d_pue;
  logic             sel_adc;

  // read word per port
  wire  logic [7:0] b_read;
  wire  logic [6:0] c_read;
  wire  logic [7:0] d_read;

  // third-port ownership
  logic       [3:0] spi_own;
  logic       [3:0] tmr_own;
  logic       [7:0] d_own;
  logic       [7:0] d_pout;
  logic       [7:0] d_poe;

  // next pin drive, per bit
  wire  logic [7:0] b_oe_nx;
  wire  logic [6:0] c_oe_nx;
  wire  logic [6:0] c_pu_nx;
  wire  logic [7:0] d_out_nx;
  wire  logic [7:0] d_oe_nx;
  wire  logic [7:0] d_pu_nx;

  // analog channel decode
  logic             analog_valid;
  logic       [7:0] analog;

  // address decode; unmapped addresses select nothing
  always_comb begin
    sel_b_data = 1'b0;
    sel_c_data = 1'b0;
    sel_d_data = 1'b0;

    sel_b_dir  = 1'b0;
    sel_c_dir  = 1'b0;
    sel_d_dir  = 1'b0;

    sel_c_pue  = 1'b0;
    sel_d_pue  = 1'b0;
    sel_adc    = 1'b0;

    case (bus.addr)
      gpbcd_pkg::GPBCD_OFS_B_DATA: begin
        sel_b_data = 1'b1;
      end

      gpbcd_pkg::GPBCD_OFS_C_DATA: begin
        sel_c_data = 1'b1;
      end

      gpbcd_pkg::GPBCD_OFS_D_DATA: begin
        sel_d_data = 1'b1;
      end

      gpbcd_pkg::GPBCD_OFS_B_DIR: begin
        sel_b_dir = 1'b1;
      end

      gpbcd_pkg::GPBCD_OFS_C_DIR: begin
        sel_c_dir = 1'b1;
      end

      gpbcd_pkg::GPBCD_OFS_D_DIR: begin
        sel_d_dir = 1'b1;
      end

      gpbcd_pkg::GPBCD_OFS_C_PUE: begin
        sel_c_pue = 1'b1;
      end

      gpbcd_pkg::GPBCD_OFS_D_PUE: begin
        sel_d_pue = 1'b1;
      end

      gpbcd_pkg::GPBCD_OFS_ADC_SEL: begin
        sel_adc = 1'b1;
      end

      default: begin
        sel_b_data = 1'b0;
      end
    endcase
  end

  // direction picks latch or pin, also on peripheral-owned pins
  for (genvar i = 0; i < 8; i++) begin : g_b_read
    assign b_read[i] = s_q.port_b_direction[i] ? s_q.port_b_data_latch[i] : s_q.b_sync[i];
  end

  for (genvar i = 0; i < 7; i++) begin : g_c_read
    assign c_read[i] = s_q.port_c_direction[i] ? s_q.port_c_data_latch[i] : s_q.c_sync[i];
  end

  for (genvar i = 0; i < 8; i++) begin : g_d_read
    assign d_read[i] = s_q.port_d_direction[i] ? s_q.port_d_data_latch[i] : s_q.d_sync[i];
  end

  // sck, mosi and miso follow the enable alone; ss also needs slave mode
  assign spi_own = {periph.spi_enable_signal,
                    periph.spi_enable_signal,
                    periph.spi_enable_signal,
                    periph.spi_enable_signal & ~periph.spi_master_select};
  assign tmr_own = periph.tmr_active;
  assign d_own   = {tmr_own, spi_own};
  assign d_pout  = {periph.tmr_out, periph.spi_out};
  assign d_poe   = {periph.tmr_oe, periph.spi_oe};

  // out-of-range channel codes leave every pin digital
  assign analog_valid = (s_q.converter_channel_select < 5'(gpbcd_pkg::GPBCD_ADC_CHANS));

  always_comb begin
    analog = 8'h00;
    if (analog_valid) begin
      analog[s_q.converter_channel_select[2:0]] = 1'b1;
    end
  end

  // an analog pin is never driven by the port
  for (genvar i = 0; i < 8; i++) begin : g_b_drive
    assign b_oe_nx[i] = s_q.port_b_direction[i] & ~analog[i];
  end

  // pullup only while the pin is an input
  for (genvar i = 0; i < 7; i++) begin : g_c_drive
    assign c_oe_nx[i] = s_q.port_c_direction[i];
    assign c_pu_nx[i] = s_q.port_c_pullup_enable[i] & ~s_q.port_c_direction[i];
  end

  // owned pins take the peripheral's drive; pullup follows the real driver
  for (genvar i = 0; i < 8; i++) begin : g_d_drive
    assign d_out_nx[i] = d_own[i] ? d_pout[i] : s_q.port_d_data_latch[i];
    assign d_oe_nx[i]  = d_own[i] ? d_poe[i] : s_q.port_d_direction[i];
    assign d_pu_nx[i]  = s_q.port_d_pullup_enable[i] & ~d_oe_nx[i];
  end

  always_comb begin
    s_d = s_q;

    // two-stage synchronizer; only the second stage is read
    s_d.b_meta = b_pin_in;
    s_d.b_sync = s_q.b_meta;
    s_d.c_meta = c_pin_in;
    s_d.c_sync = s_q.c_meta;
    s_d.d_meta = d_pin_in;
    s_d.d_sync = s_q.d_meta;

    // writes: latches take a write whatever the direction
    if (bus.wr) begin
      if (sel_b_data) begin
        s_d.port_b_data_latch = bus.wdata;
      end

      if (sel_c_data) begin
        s_d.port_c_data_latch = bus.wdata[6:0];
      end

      if (sel_d_data) begin
        s_d.port_d_data_latch = bus.wdata;
      end

      if (sel_b_dir) begin
        s_d.port_b_direction = bus.wdata;
      end

      // bit 7 of the seven-bit port has no storage
      if (sel_c_dir) begin
        s_d.port_c_direction = bus.wdata[6:0];
      end

      if (sel_d_dir) begin
        s_d.port_d_direction = bus.wdata;
      end

      if (sel_c_pue) begin
        s_d.port_c_pullup_enable = bus.wdata[6:0];
      end

      if (sel_d_pue) begin
        s_d.port_d_pullup_enable = bus.wdata;
      end

      if (sel_adc) begin
        s_d.converter_channel_select = bus.wdata[4:0];
      end
    end

    // reads: data stand one cycle after the strobe; unmapped reads zero
    s_d.rdata = 8'h00;
    if (bus.rd) begin
      if (sel_b_data) begin
        s_d.rdata = b_read;
      end

      if (sel_c_data) begin
        s_d.rdata = {1'b0, c_read};
      end

      if (sel_d_data) begin
        s_d.rdata = d_read;
      end

      if (sel_b_dir) begin
        s_d.rdata = s_q.port_b_direction;
      end

      if (sel_c_dir) begin
        s_d.rdata = {1'b0, s_q.port_c_direction};
      end

      if (sel_d_dir) begin
        s_d.rdata = s_q.port_d_direction;
      end

      if (sel_c_pue) begin
        s_d.rdata = {1'b0, s_q.port_c_pullup_enable};
      end

      if (sel_d_pue) begin
        s_d.rdata = s_q.port_d_pullup_enable;
      end

      if (sel_adc) begin
        s_d.rdata = {3'h0, s_q.converter_channel_select};
      end
    end

    // pin drive, registered so every output comes from a flop
    s_d.b_out    = s_q.port_b_data_latch;
    s_d.b_oe     = b_oe_nx;
    s_d.b_analog = analog;

    s_d.c_out    = s_q.port_c_data_latch;
    s_d.c_oe     = c_oe_nx;
    s_d.c_pu     = c_pu_nx;

    s_d.d_out    = d_out_nx;
    s_d.d_oe     = d_oe_nx;
    s_d.d_pu     = d_pu_nx;
  end

  // latches and drive values are left out of the reset branch, so they hold through it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q.port_b_direction         <= gpbcd_pkg::GPBCD_DIR_RST;
      s_q.port_c_direction         <= gpbcd_pkg::GPBCD_DIR_RST[6:0];
      s_q.port_d_direction         <= gpbcd_pkg::GPBCD_DIR_RST;

      s_q.port_c_pullup_enable     <= gpbcd_pkg::GPBCD_PUE_RST[6:0];
      s_q.port_d_pullup_enable     <= gpbcd_pkg::GPBCD_PUE_RST;
      s_q.converter_channel_select <= gpbcd_pkg::GPBCD_ADC_RST;

      s_q.b_meta                   <= 8'h00;
      s_q.b_sync                   <= 8'h00;
      s_q.c_meta                   <= 7'h00;
      s_q.c_sync                   <= 7'h00;
      s_q.d_meta                   <= 8'h00;
      s_q.d_sync                   <= 8'h00;

      s_q.rdata                    <= 8'h00;
      s_q.b_oe                     <= 8'h00;
      s_q.b_analog                 <= 8'h00;
      s_q.c_oe                     <= 7'h00;
      s_q.c_pu                     <= 7'h00;
      s_q.d_oe                     <= 8'h00;
      s_q.d_pu                     <= 8'h00;
    end else begin
      s_q.port_b_data_latch        <= s_d.port_b_data_latch;
      s_q.port_c_data_latch        <= s_d.port_c_data_latch;
      s_q.port_d_data_latch        <= s_d.port_d_data_latch;

      s_q.port_b_direction         <= s_d.port_b_direction;
      s_q.port_c_direction         <= s_d.port_c_direction;
      s_q.port_d_direction         <= s_d.port_d_direction;

      s_q.port_c_pullup_enable     <= s_d.port_c_pullup_enable;
      s_q.port_d_pullup_enable     <= s_d.port_d_pullup_enable;
      s_q.converter_channel_select <= s_d.converter_channel_select;

      s_q.b_meta                   <= s_d.b_meta;
      s_q.b_sync                   <= s_d.b_sync;
      s_q.c_meta                   <= s_d.c_meta;
      s_q.c_sync                   <= s_d.c_sync;
      s_q.d_meta                   <= s_d.d_meta;
      s_q.d_sync                   <= s_d.d_sync;

      s_q.rdata                    <= s_d.rdata;

      s_q.b_out                    <= s_d.b_out;
      s_q.b_oe                     <= s_d.b_oe;
      s_q.b_analog                 <= s_d.b_analog;

      s_q.c_out                    <= s_d.c_out;
      s_q.c_oe                     <= s_d.c_oe;
      s_q.c_pu                     <= s_d.c_pu;

      s_q.d_out                    <= s_d.d_out;
      s_q.d_oe                     <= s_d.d_oe;
      s_q.d_pu                     <= s_d.d_pu;
    end
  end

  assign rdata        = s_q.rdata;

  assign b_pin_out    = s_q.b_out;
  assign b_pin_oe     = s_q.b_oe;
  assign b_analog_sel = s_q.b_analog;

  assign c_pin_out    = s_q.c_out;
  assign c_pin_oe     = s_q.c_oe;
  assign c_pullup_on  = s_q.c_pu;

  assign d_pin_out    = s_q.d_out;
  assign d_pin_oe     = s_q.d_oe;
  assign d_pullup_on  = s_q.d_pu;

  // peripherals see the same synchronized levels as a data read
  assign d_spi_in     = s_q.d_sync;

endmodule : gpbcd_ports
`default_nettype wire

/* test/gpbcd_checker.sv */
// assertion checker for the port block
`timescale 1ns/100ps
`default_nettype none
module gpbcd_checker (
  input wire logic                     ref_clk,
  input wire logic                     rst,
  input wire gpbcd_pkg::gpbcd_bus_s    bus,
  input wire logic [7:0]               rdata,
  input wire gpbcd_pkg::gpbcd_periph_s periph,
  input wire logic [7:0]               b_pin_in,
  input wire logic [7:0]               b_pin_out,
  input wire logic [7:0]               b_pin_oe,
  input wire logic [7:0]               b_analog_sel,
  input wire logic [6:0]               c_pin_oe,
  input wire logic [6:0]               c_pullup_on,
  input wire logic [7:0]               d_pin_oe,
  input wire logic [7:0]               d_pullup_on
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_dir_reset; $fell(rst) |-> b_pin_oe == 8'h00 && c_pin_oe == 7'h00 && d_pin_oe == 8'h00; endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("driver on after reset");
  property p_dir_drive; bus.wr && bus.addr == 4'h6 ##1 !(bus.wr && bus.addr == 4'h6) |=> c_pin_oe == $past(bus.wdata[6:0], 2); endproperty
  a_dir_drive: assert property (p_dir_drive) else $error("driver not per direction");
  property p_no_pull_out; (c_pullup_on & c_pin_oe) == 7'h00 && (d_pullup_on & d_pin_oe) == 8'h00; endproperty
  a_no_pull_out: assert property (p_no_pull_out) else $error("pullup on driven pin");
  property p_latch_out; bus.wr && bus.addr == 4'h1 ##1 !(bus.wr && bus.addr == 4'h1) |=> b_pin_out == $past(bus.wdata, 2); endproperty
  a_latch_out: assert property (p_latch_out) else $error("latch write lost");
  // three quiet cycles cover both synchronizer stages
  property p_read_pin; (!bus.wr && b_pin_oe == 8'h00 && b_analog_sel == 8'h00 && $stable(b_pin_in)) [*3] ##0
    (bus.rd && bus.addr == 4'h1) |=> rdata == $past(b_pin_in); endproperty
  a_read_pin: assert property (p_read_pin) else $error("input read not pin");
  property p_analog; $onehot0(b_analog_sel) && (b_pin_oe & b_analog_sel) == 8'h00; endproperty
  a_analog: assert property (p_analog) else $error("analog pin driven");
  property p_spi_own; periph.spi_enable_signal && !periph.spi_master_select |=> d_pin_oe[3:0] == $past(periph.spi_oe); endproperty
  a_spi_own: assert property (p_spi_own) else $error("spi pin not spi driven");
  property p_rdata_idle; !bus.rd |=> rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
  c_read_d: cover property (bus.rd && bus.addr == 4'h3);
  c_spi_master: cover property (periph.spi_enable_signal && periph.spi_master_select);
  c_timer: cover property (periph.tmr_active != 4'h0);
endmodule : gpbcd_checker
bind gpbcd_ports gpbcd_checker chk (.ref_clk, .rst, .bus, .rdata, .periph, .b_pin_in, .b_pin_out, .b_pin_oe,
  .b_analog_sel, .c_pin_oe, .c_pullup_on, .d_pin_oe, .d_pullup_on);
`default_nettype wire

/* test/gpbcd_pin_model.sv */
// outside world of the pins: drivers, pullups and outside levels
`timescale 1ns/100ps
`default_nettype none
module gpbcd_pin_model (
  input  wire logic        ref_clk,
  input  wire logic [7:0]  ext_lvl,
  input  wire logic [7:0]  ext_en,
  input  wire logic [22:0] out,
  input  wire logic [22:0] oe,
  input  wire logic [22:0] pu,
  output wire logic [22:0] pin
);
  logic        flt_q = 1'b0;
  wire  logic [22:0] en = {ext_en, ext_en[6:0], ext_en};
  wire  logic [22:0] lv = {ext_lvl, ext_lvl[6:0], ext_lvl};
  // floating lines toggle so a stale level never reads as right
  always @(posedge ref_clk) flt_q <= ~flt_q;
  assign pin = (oe & out) | (~oe & en & lv) | (~oe & ~en & (pu | {23{flt_q}}));
endmodule : gpbcd_pin_model
`default_nettype wire

/* test/gpbcd_ports_bench.sv */
// self-checking bench of the port block
`timescale 1ns/100ps
`default_nettype none
module gpbcd_ports_bench;
  logic                     ref_clk = 1'b0;
  logic                     rst = 1'b1;
  gpbcd_pkg::gpbcd_bus_s    bus = '0;
  gpbcd_pkg::gpbcd_periph_s periph = '0;
  logic [7:0]               rdata, b_an, lat, ext_lvl = 8'h00, ext_en = 8'hFF;
  wire  logic [22:0]        out, oe, pu, pin;
  wire  logic [7:0]         d_spi;
  logic [31:0]              r1, r2, seed = 32'h0000_005E;
  int                       fail_count = 0, compares = 0;
  always #4 ref_clk = ~ref_clk;
  gpbcd_ports uut (.ref_clk, .rst, .bus, .rdata, .periph, .b_pin_in(pin[7:0]), .b_pin_out(out[7:0]),
    .b_pin_oe(oe[7:0]), .b_analog_sel(b_an), .c_pin_in(pin[14:8]), .c_pin_out(out[14:8]), .c_pin_oe(oe[14:8]),
    .c_pullup_on(pu[14:8]), .d_pin_in(pin[22:15]), .d_pin_out(out[22:15]), .d_pin_oe(oe[22:15]),
    .d_pullup_on(pu[22:15]), .d_spi_in(d_spi));
  assign pu[7:0] = 8'h00;
  gpbcd_pin_model pins (.ref_clk, .ext_lvl, .ext_en, .out, .oe, .pu, .pin);
  function automatic logic [7:0] pick(input logic [7:0] dir, input logic [7:0] lt, input logic [7:0] pn);
    return (dir & lt) | (~dir & pn);
  endfunction : pick
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk) bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk) bus.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle
  task automatic end_of_test;
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 5; a < 8; a++) rd(4'(a), 8'h00);
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      r1 = seed;
      seed = xs(seed);
      r2 = seed;
      lat = r1[7:0];
      ext_lvl <= r2[7:0];
      // latch first, direction after: no glitch on switch to output
      for (int p = 1; p < 4; p++) wr(4'(p), lat);
      wr(4'h5, r1[15:8]);
      wr(4'h6, r1[23:16]);
      wr(4'h7, r1[31:24]);
      wr(4'h8, r2[15:8]);
      wr(4'h9, r2[15:8]);
      rd(4'h6, {1'b0, r1[22:16]});
      chk({1'b0, out[14:8]}, {1'b0, lat[6:0]});
      chk({1'b0, pu[14:8]}, {1'b0, r2[14:8] & ~r1[22:16]});
      chk(pu[22:15], r2[15:8] & ~r1[31:24]);
      rd(4'h1, pick(r1[15:8], lat, r2[7:0]));
      rd(4'h2, pick(r1[23:16], lat, r2[7:0]) & 8'h7F);
      rd(4'h3, pick(r1[31:24], lat, r2[7:0]));
    end
    ext_en <= 8'h00;
    wr(4'h8, 8'hFF);
    idle(4);
    rd(4'h2, pick(r1[23:16], lat, 8'hFF) & 8'h7F);
    ext_en <= 8'hFF;
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    rd(4'h7, 8'h00);
    rd(4'h1, ext_lvl);
    wr(4'h5, 8'hFF);
    rd(4'h1, lat);
    wr(4'hA, 8'h03);
    idle(2);
    chk(b_an, 8'h08);
    chk(oe[7:0], 8'hF7);
    wr(4'h7, 8'h01);
    @(posedge ref_clk) periph <= '{1'b1, 1'b0, 4'h5, 4'hE, 4'h0, 4'h0, 4'h0};
    idle(3);
    chk(oe[22:15], 8'h0E);
    chk({4'h0, out[18:15] & 4'hE}, 8'h04);
    rd(4'h3, pick(8'h01, lat, {ext_lvl[7:4], 3'b010, ext_lvl[0]}));
    chk(d_spi, {ext_lvl[7:4], 3'b010, ext_lvl[0]});
    @(posedge ref_clk) periph.spi_master_select <= 1'b1;
    idle(3);
    chk(oe[22:15], 8'h0F);
    @(posedge ref_clk) periph <= '{1'b0, 1'b0, 4'h5, 4'hE, 4'hF, 4'hA, 4'h5};
    idle(3);
    chk(oe[22:15], 8'h51);
    chk({4'h0, out[22:19]}, 8'h0A);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    end_of_test();
  end
endmodule : gpbcd_ports_bench
`default_nettype wire
